// file: hdl/fmoc_top.sv
// Fan mode and overtemperature pin configuration registers with serial slave
`default_nettype none
module fmoc_top #(
  parameter int unsigned CONV8_CYCLES  = fmoc_pkg::CONV8_CYC,
  parameter int unsigned CONV11_CYCLES = fmoc_pkg::CONV11_CYC,
  parameter logic [6:0]  SLAVE_ADDR    = fmoc_pkg::DEF_SLAVE_ADDR
) (
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        SCL,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  input  wire logic        FIRST_FAN_INPUT,
  input  wire logic        SECOND_FAN_INPUT,
  input  wire logic [3:0]  VOLTAGE_IDENT_INPUTS,
  input  wire logic        SHARED_RESET_OVERTEMP_PIN_I,
  output logic             SHARED_RESET_OVERTEMP_PIN_O,
  output logic             SHARED_RESET_OVERTEMP_PIN_OE,
  input  wire logic        RESET_REQUEST,
  input  wire logic        OVERTEMP_ABOVE_LIMIT,
  input  wire logic        OVERTEMP_BELOW_HYST,
  input  wire logic [11:0] TEMP_SAMPLE,
  output logic [7:0]       TEMP_WHOLE,
  output logic             CONV_DONE,
  output logic [7:0]       FIRST_FAN_COUNT,
  output logic [7:0]       SECOND_FAN_COUNT,
  output logic             FIRST_FAN_ALARM,
  output logic             SECOND_FAN_ALARM
);
  import fmoc_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] scl_sh_ff;
  logic [2:0] sda_sh_ff;
  logic [1:0] first_fan_input_sh_ff;
  logic [1:0] second_fan_input_sh_ff;
  logic [1:0] pin_sh_ff;
  logic [3:0] vid_s1_ff;
  logic [3:0] vid_s2_ff;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_sh_ff  <= 3'h7;
      sda_sh_ff  <= 3'h7;
      first_fan_input_sh_ff <= 2'h0;
      second_fan_input_sh_ff <= 2'h0;
      pin_sh_ff  <= 2'h3;
      vid_s1_ff  <= 4'h0;
      vid_s2_ff  <= 4'h0;
    end else begin
      scl_sh_ff  <= {scl_sh_ff[1:0], SCL};
      sda_sh_ff  <= {sda_sh_ff[1:0], SDA_I};
      first_fan_input_sh_ff <= {first_fan_input_sh_ff[0], FIRST_FAN_INPUT};
      second_fan_input_sh_ff <= {second_fan_input_sh_ff[0], SECOND_FAN_INPUT};
      pin_sh_ff  <= {pin_sh_ff[0], SHARED_RESET_OVERTEMP_PIN_I};
      vid_s1_ff  <= VOLTAGE_IDENT_INPUTS;
      vid_s2_ff  <= vid_s1_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_sh_ff[1] && !scl_sh_ff[2];
  assign scl_fall  = !scl_sh_ff[1] && scl_sh_ff[2];
  assign sda_lvl   = sda_sh_ff[1];
  assign bus_start = scl_sh_ff[1] && scl_sh_ff[2] && !sda_sh_ff[1] && sda_sh_ff[2];
  assign bus_stop  = scl_sh_ff[1] && scl_sh_ff[2] && sda_sh_ff[1] && !sda_sh_ff[2];

  // ---------------------------------------------------------------
  // Serial slave: pointer byte, then data writes or reads
  // ---------------------------------------------------------------
  fmoc_bus_state_t state_ff;
  logic [3:0]      bit_cnt_ff;
  logic [7:0]      rx_ff;
  logic [7:0]      tx_ff;
  logic [7:0]      ptr_ff;
  logic [7:0]      wdata_ff;
  logic            wstb_ff;
  logic            rstb_ff;
  logic            rw_ff;
  logic            first_ff;
  logic            sda_oe_ff;
  logic [7:0]      rd_data;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      ptr_ff     <= 8'h00;
      wdata_ff   <= 8'h00;
      wstb_ff    <= 1'b0;
      rstb_ff    <= 1'b0;
      rw_ff      <= 1'b0;
      first_ff   <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else begin
      wstb_ff <= 1'b0;
      rstb_ff <= 1'b0;
      if (bus_start) begin
        state_ff   <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff  <= 1'b0;
      end else if (bus_stop) begin
        state_ff  <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        rx_ff      <= {rx_ff[6:0], sda_lvl};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        // Master NACK ends a read burst
        if (state_ff == ST_RD_ACK && sda_lvl) begin
          state_ff <= ST_IDLE;
        end
      end else if (scl_fall) begin
        unique case (state_ff)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (bit_cnt_ff == BYTE_BITS) begin
              if (rx_ff[7:1] == SLAVE_ADDR) begin
                state_ff  <= ST_ADDR_ACK;
                sda_oe_ff <= 1'b1;
                rw_ff     <= rx_ff[0];
                first_ff  <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            if (rw_ff) begin
              state_ff   <= ST_RD;
              sda_oe_ff  <= !rd_data[7];
              tx_ff      <= {rd_data[6:0], 1'b0};
              bit_cnt_ff <= 4'h0;
              rstb_ff    <= 1'b1;
            end else begin
              state_ff   <= ST_WR;
              sda_oe_ff  <= 1'b0;
              bit_cnt_ff <= 4'h0;
            end
          end
          ST_WR: begin
            if (bit_cnt_ff == BYTE_BITS) begin
              state_ff  <= ST_WR_ACK;
              sda_oe_ff <= 1'b1;
              first_ff  <= 1'b0;
              if (first_ff) begin
                ptr_ff <= rx_ff;
              end else begin
                wdata_ff <= rx_ff;
                wstb_ff  <= 1'b1;
              end
            end
          end
          ST_WR_ACK: begin
            state_ff   <= ST_WR;
            sda_oe_ff  <= 1'b0;
            bit_cnt_ff <= 4'h0;
          end
          ST_RD: begin
            if (bit_cnt_ff == BYTE_BITS) begin
              state_ff  <= ST_RD_ACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sda_oe_ff <= !tx_ff[7];
              tx_ff     <= {tx_ff[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] fan_cfg_ff;
  logic [1:0] strap_cnt_ff;
  logic       pol_ff;
  logic       mode_ff;
  logic       res_ff;
  logic [3:0] nib_ff;
  logic       status_ff;
  logic       conv_end;
  logic       wr_fan;
  logic       wr_ot;

  assign wr_fan = wstb_ff && (ptr_ff == REG_FAN_CFG);
  assign wr_ot  = wstb_ff && (ptr_ff == REG_OT_CFG);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fan_cfg_ff   <= FAN_CFG_RST;
      strap_cnt_ff <= 2'h0;
    end else begin
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      // Straps are caught once, after they have settled through the synchroniser
      if (strap_cnt_ff == STRAP_LOAD) begin
        fan_cfg_ff[3:0] <= vid_s2_ff;
      end else if (wr_fan) begin
        fan_cfg_ff <= wdata_ff;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pol_ff  <= OT_CFG_RST[OC_POL];
      mode_ff <= OT_CFG_RST[OC_MODE];
      res_ff  <= OT_CFG_RST[OC_RES];
      nib_ff  <= OT_CFG_RST[7:OC_NIB];
    end else begin
      if (wr_ot) begin
        pol_ff  <= wdata_ff[OC_POL];
        mode_ff <= wdata_ff[OC_MODE];
        res_ff  <= wdata_ff[OC_RES];
        nib_ff  <= wdata_ff[7:OC_NIB];
      end
      // A finishing conversion wins over a host write to the nibble
      if (conv_end) begin
        nib_ff <= res_ff ? TEMP_SAMPLE[3:0] : {TEMP_SAMPLE[HALF_DEG_BIT], 3'h0};
      end
    end
  end

  always_comb begin
    unique case (ptr_ff)
      REG_FAN_CFG: rd_data = fan_cfg_ff;
      REG_OT_CFG:  rd_data = {nib_ff, res_ff, mode_ff, pol_ff, status_ff};
      default:     rd_data = UNMAPPED_READ;
    endcase
  end

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  logic [CONV_CNT_W-1:0] conv_cnt_ff;
  logic [CONV_CNT_W-1:0] conv_last;
  logic                  conv_done_ff;
  logic [7:0]            temp_whole_ff;

  assign conv_last = res_ff ? CONV_CNT_W'(CONV11_CYCLES - 1) : CONV_CNT_W'(CONV8_CYCLES - 1);
  assign conv_end  = conv_cnt_ff >= conv_last;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      conv_cnt_ff   <= '0;
      conv_done_ff  <= 1'b0;
      temp_whole_ff <= 8'h00;
    end else begin
      conv_done_ff <= conv_end;
      if (conv_end) begin
        conv_cnt_ff   <= '0;
        temp_whole_ff <= TEMP_SAMPLE[11:4];
      end else begin
        conv_cnt_ff <= conv_cnt_ff + CONV_CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Overtemperature event and shared pin drive
  // ---------------------------------------------------------------
  logic ot_active_ff;
  logic armed_ff;
  logic pin_oe_ff;
  logic zero_ff;
  logic reset_mode;
  logic ot_mode;
  logic rd_clear;

  assign reset_mode = fan_cfg_ff[FC_RESET_EN];
  assign ot_mode    = fan_cfg_ff[FC_OT_EN] && !reset_mode;
  assign rd_clear   = rstb_ff && (ptr_ff == REG_OT_CFG);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ot_active_ff <= 1'b0;
      armed_ff     <= 1'b1;
    end else if (mode_ff) begin
      // One-time: one event per excursion, re-armed below hysteresis
      if (OVERTEMP_ABOVE_LIMIT && armed_ff) begin
        ot_active_ff <= 1'b1;
        armed_ff     <= 1'b0;
      end else if (rd_clear) begin
        ot_active_ff <= 1'b0;
      end
      if (OVERTEMP_BELOW_HYST) begin
        armed_ff <= 1'b1;
      end
    end else begin
      armed_ff <= 1'b1;
      if (OVERTEMP_ABOVE_LIMIT) begin
        ot_active_ff <= 1'b1;
      end else if (OVERTEMP_BELOW_HYST) begin
        ot_active_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_oe_ff <= 1'b0;
      status_ff <= OT_CFG_RST[OC_STATUS];
      zero_ff   <= 1'b0;
    end else begin
      zero_ff <= 1'b0;
      // Open drain: only ever pull low, release lets the line float high
      if (reset_mode) begin
        pin_oe_ff <= RESET_REQUEST;
      end else if (ot_mode) begin
        pin_oe_ff <= ot_active_ff ^ pol_ff;
      end else begin
        pin_oe_ff <= 1'b0;
      end
      status_ff <= ot_mode ? pin_sh_ff[1] : 1'b1;
    end
  end

  assign SDA_O                        = zero_ff;
  assign SDA_OE                       = sda_oe_ff;
  assign SHARED_RESET_OVERTEMP_PIN_O  = zero_ff;
  assign SHARED_RESET_OVERTEMP_PIN_OE = pin_oe_ff;
  assign TEMP_WHOLE                   = temp_whole_ff;
  assign CONV_DONE                    = conv_done_ff;

  // ---------------------------------------------------------------
  // Fan channels
  // ---------------------------------------------------------------
  logic [FAN_TICK_W-1:0] tick_cnt_ff;
  logic                  base_tick;

  assign base_tick = tick_cnt_ff == FAN_TICK_W'(FAN_TICK_CYC - 1);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= base_tick ? '0 : tick_cnt_ff + FAN_TICK_W'(1);
    end
  end

  fmoc_fan_chan u_first_fan (
    .mclk       (MCLK),
    .arst_n     (ARST_N),
    .fan_lvl    (first_fan_input_sh_ff[1]),
    .level_mode (fan_cfg_ff[FC_FIRST_MODE]),
    .active_low (fan_cfg_ff[FC_LEVEL_POL]),
    .div_code   (fan_cfg_ff[FC_FIRST_DIV+:2]),
    .base_tick  (base_tick),
    .count      (FIRST_FAN_COUNT),
    .alarm      (FIRST_FAN_ALARM)
  );

  fmoc_fan_chan u_second_fan (
    .mclk       (MCLK),
    .arst_n     (ARST_N),
    .fan_lvl    (second_fan_input_sh_ff[1]),
    .level_mode (fan_cfg_ff[FC_SECOND_MODE]),
    .active_low (fan_cfg_ff[FC_LEVEL_POL]),
    .div_code   (fan_cfg_ff[FC_SECOND_DIV+:2]),
    .base_tick  (base_tick),
    .count      (SECOND_FAN_COUNT),
    .alarm      (SECOND_FAN_ALARM)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_host_write_ot;
    wstb_ff && (ptr_ff == REG_OT_CFG);
  endsequence
  sequence s_host_write_fan;
    wstb_ff && (ptr_ff == REG_FAN_CFG) && (strap_cnt_ff != STRAP_LOAD);
  endsequence

  a_pin_disabled: assert property (fan_cfg_ff[7:6] == 2'h0 |=> !SHARED_RESET_OVERTEMP_PIN_OE)
    else $error("shared pin driven while disabled");
  a_reset_mode_pin: assert property (reset_mode |=> SHARED_RESET_OVERTEMP_PIN_OE == $past(RESET_REQUEST))
    else $error("reset mode pin does not follow request");
  a_overtemp_drive: assert property (ot_mode |=> SHARED_RESET_OVERTEMP_PIN_OE == ($past(ot_active_ff) != $past(pol_ff)))
    else $error("overtemperature pin drive wrong for polarity");
  a_status_mirror: assert property (ot_mode |=> status_ff == $past(pin_sh_ff[1]))
    else $error("status bit does not mirror pin");
  a_ot_cfg_write: assert property (s_host_write_ot |=> pol_ff == $past(wdata_ff[OC_POL]) && res_ff == $past(wdata_ff[OC_RES]))
    else $error("overtemperature config write lost");
  a_fan_cfg_write: assert property (s_host_write_fan |=> fan_cfg_ff == $past(wdata_ff))
    else $error("fan config write lost");
  a_one_time_event: assert property ($past(mode_ff) && $rose(ot_active_ff) |-> $past(armed_ff) && !armed_ff)
    else $error("one-time event fired while not armed");
  a_conv_restart: assert property (conv_end |=> conv_done_ff && conv_cnt_ff == '0)
    else $error("conversion did not restart");
  a_nibble_coarse: assert property (conv_end && !res_ff |=> nib_ff == {$past(TEMP_SAMPLE[HALF_DEG_BIT]), 3'h0})
    else $error("coarse nibble wrong");
  a_nibble_fine: assert property (conv_end && res_ff |=> nib_ff == $past(TEMP_SAMPLE[3:0]))
    else $error("fine nibble wrong");
  a_strap_load: assert property (strap_cnt_ff == STRAP_LOAD |=> fan_cfg_ff[3:0] == $past(vid_s2_ff))
    else $error("strap pins not loaded");
endmodule // fmoc_top
`default_nettype wire

// file: shared/fmoc_pkg.sv
// Constants and types for the fan mode and overtemperature pin configuration block
// What this block does
// - Fan config bit 0: first fan level mode
// - Fan config bit 1: second fan level mode
// - Bits 3:2 divide first fan count by 1/2/4/8
// - Bits 5:4 divide second fan count by 1/2/4/8
// - Bit 2 sets level-mode alarm polarity
// - Bit 6 with bit 7 low: overtemperature pin
// - Bits 7:6 both zero disable shared pin
// - Bit 7 set: shared pin in reset mode
// - Status bit mirrors pin in overtemperature mode
// - Bit 1 sets polarity; pin is open-drain
// - Bit 2 picks one-time or comparator behaviour
// - Bit 3 picks 8-bit or 11-bit conversions
// - Conversions take 100 ms or 2 s
// - 11-bit mode: bits 7:4 hold fine nibble
// - 8-bit mode: bit 7 is 0.5 degree
// - Fan config resets to 0101 plus strap pins
// - Overtemperature config resets to 0x01
// - Fan reading counts clocks per revolution, scaled
`default_nettype none
package fmoc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_FAN_CFG    = 8'h05;
  localparam logic [7:0] REG_OT_CFG     = 8'h06;
  localparam logic [3:0] FAN_CFG_HI_RST = 4'h5;
  localparam logic [7:0] FAN_CFG_RST    = {FAN_CFG_HI_RST, 4'h0};
  localparam logic [7:0] OT_CFG_RST     = 8'h01;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  // Fan config fields
  localparam int FC_FIRST_MODE   = 0;
  localparam int FC_SECOND_MODE  = 1;
  localparam int FC_LEVEL_POL    = 2;
  localparam int FC_FIRST_DIV    = 2;
  localparam int FC_SECOND_DIV   = 4;
  localparam int FC_OT_EN        = 6;
  localparam int FC_RESET_EN     = 7;
  // Overtemperature config fields
  localparam int OC_STATUS       = 0;
  localparam int OC_POL          = 1;
  localparam int OC_MODE         = 2;
  localparam int OC_RES          = 3;
  localparam int OC_NIB          = 4;
  localparam int HALF_DEG_BIT    = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned CONV8_MS    = 100;
  localparam int unsigned CONV11_S    = 2;
  localparam int unsigned CONV8_CYC   = CONV8_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV11_CYC  = CONV11_S * CLK_HZ;
  localparam int          CONV_CNT_W  = 26;
  localparam int unsigned FAN_TICK_HZ = 20_000;
  localparam int unsigned FAN_TICK_CYC = CLK_HZ / FAN_TICK_HZ;
  localparam int          FAN_TICK_W  = 10;
  localparam logic [1:0]  STRAP_LOAD  = 2'h2;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  // Arbitrary serial slave address
  localparam logic [6:0]  DEF_SLAVE_ADDR = 7'h2C;
  // ---------------------------------------------------------------
  // Serial slave states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR       = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD       = 7'h20,
    ST_RD_ACK   = 7'h40
  } fmoc_bus_state_t;
endpackage
`default_nettype wire

// file: hdl/fmoc_fan_chan.sv
// One fan input channel: revolution counter or level alarm
`default_nettype none
module fmoc_fan_chan (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       fan_lvl,
  input  wire logic       level_mode,
  input  wire logic       active_low,
  input  wire logic [1:0] div_code,
  input  wire logic       base_tick,
  output logic [7:0]      count,
  output logic            alarm
);
  import fmoc_pkg::*;

  logic       fan_prev_ff;
  logic [2:0] div_cnt_ff;
  logic [7:0] run_ff;
  logic [7:0] count_ff;
  logic       alarm_ff;
  logic [2:0] div_last;
  logic       cnt_tick;
  logic       fan_rise;

  // 3-bit wrap makes code 3 give 7
  assign div_last = (3'h1 << div_code) - 3'h1;
  assign cnt_tick = base_tick && (div_cnt_ff == div_last);
  assign fan_rise = fan_lvl && !fan_prev_ff;
  assign count    = count_ff;
  assign alarm    = alarm_ff;

  // ---------------------------------------------------------------
  // Counting clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 3'h0;
    end else if (base_tick) begin
      div_cnt_ff <= (div_cnt_ff == div_last) ? 3'h0 : div_cnt_ff + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Period measurement
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fan_prev_ff <= 1'b0;
      run_ff      <= 8'h00;
      count_ff    <= 8'h00;
    end else begin
      fan_prev_ff <= fan_lvl;
      if (level_mode) begin
        run_ff <= 8'h00;
      end else if (fan_rise) begin
        count_ff <= run_ff;
        run_ff   <= 8'h00;
      end else if (cnt_tick) begin
        // Stalled fan: publish full scale rather than a stale count
        if (run_ff == 8'hFF) begin
          count_ff <= 8'hFF;
        end else begin
          run_ff <= run_ff + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= level_mode && (fan_lvl != active_low);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_level_alarm_pol: assert property (level_mode && fan_lvl && !active_low |=> alarm_ff)
    else $error("level alarm missed active-high input");
  a_count_mode_quiet: assert property (!level_mode |=> !alarm_ff)
    else $error("alarm raised in counting mode");
  a_div_wrap: assert property (cnt_tick |=> div_cnt_ff == 3'h0)
    else $error("divider did not wrap after counting tick");
  a_period_capture: assert property (!level_mode && fan_rise |=> count_ff == $past(run_ff) && run_ff == 8'h00)
    else $error("revolution count not captured");
endmodule // fmoc_fan_chan
`default_nettype wire

// file: verification/fmoc_host_model.sv
// Serial bus host model that reaches the configuration registers
`default_nettype none
module fmoc_host_model (
  input  wire logic mclk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] addr = fmoc_pkg::DEF_SLAVE_ADDR;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Five clocks per quarter bit leaves room for the slave's sync delay
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_low = !d;
    repeat (5) @(posedge mclk);
    #2;
  endtask
  task automatic bit_io(input logic d, output logic r);
    step(1'h0, d);
    step(1'h1, d);
    r = sda;
    step(1'h1, d);
    step(1'h0, d);
  endtask
  // Ninth bit is always released: ack from slave, or our own nack on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'h1, a);
  endtask
  task automatic start();
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask
  task automatic stop();
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({addr, 1'h0}, r);
    byte_io(p, r);
    byte_io(d, r);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({addr, 1'h0}, r);
    byte_io(p, r);
    start();
    byte_io({addr, 1'h1}, r);
    byte_io(8'hFF, d);
    stop();
  endtask
endmodule // fmoc_host_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking testbench for the fan mode and overtemperature pin configuration block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, arst_n, rst_req, above, below, first_fan_input, second_fan_input, spin, scl, sda_low;
  logic        sda_o, sda_oe, pin_o, pin_oe, done, al1, al2;
  logic [7:0]  rd, whole, c1, c2;
  logic [11:0] temp;
  logic [3:0]  voltage_ident_inputs;
  wire logic   sda = !(sda_low || sda_oe);
  int          n_errors = 0, checked = 0, cyc = 0, n;
  // Write value, reset request, expected pin pull-down
  logic [9:0]  rows [6] = '{10'h203, 10'h200, 10'h30F, 10'h0F2, 10'h102, 10'h154};
  fmoc_top #(.CONV8_CYCLES(50), .CONV11_CYCLES(200)) dut (.MCLK(mclk), .ARST_N(arst_n), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .FIRST_FAN_INPUT(first_fan_input), .SECOND_FAN_INPUT(second_fan_input), .VOLTAGE_IDENT_INPUTS(voltage_ident_inputs),
    .SHARED_RESET_OVERTEMP_PIN_I(!pin_oe), .SHARED_RESET_OVERTEMP_PIN_O(pin_o), .SHARED_RESET_OVERTEMP_PIN_OE(pin_oe),
    .RESET_REQUEST(rst_req), .OVERTEMP_ABOVE_LIMIT(above), .OVERTEMP_BELOW_HYST(below), .TEMP_SAMPLE(temp),
    .TEMP_WHOLE(whole), .CONV_DONE(done), .FIRST_FAN_COUNT(c1), .SECOND_FAN_COUNT(c2), .FIRST_FAN_ALARM(al1),
    .SECOND_FAN_ALARM(al2));
  fmoc_host_model host (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic conclude();
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(3);
  endtask
  task automatic near(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    chk({7'h0, got >= lo && got <= hi}, 8'h01);
  endtask
  // Cycles between two end-of-conversion pulses
  task automatic period(input logic [7:0] e);
    @(posedge done);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (done !== 1'h1 && n < 999);
    chk(8'(n), e);
  endtask
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  // Fan period of 4000 clocks, four base ticks per revolution
  always begin
    tick(2000);
    if (spin) begin
      first_fan_input = ~first_fan_input;
      second_fan_input = first_fan_input;
    end
  end
  initial begin
    {arst_n, rst_req, above, below, first_fan_input, second_fan_input, spin} = 7'h0;
    temp = 12'h192;
    voltage_ident_inputs = 4'hA;
    tick(6);
    arst_n = 1'h1;
    tick(4);
    host.read_reg(8'h05, rd);
    chk(rd, 8'h5A);
    host.read_reg(8'h06, rd);
    chk(rd, 8'h01);
    foreach (rows[i]) begin
      rst_req = rows[i][1];
      host.write_reg(8'h05, rows[i][9:2]);
      host.read_reg(8'h05, rd);
      chk(rd, rows[i][9:2]);
      chk({7'h0, pin_oe}, {7'h0, rows[i][0]});
    end
    host.read_reg(8'h07, rd);
    chk(rd, 8'h00);
    host.addr = host.addr ^ 7'h01;
    host.write_reg(8'h05, 8'hFF);
    host.addr = host.addr ^ 7'h01;
    host.read_reg(8'h05, rd);
    chk(rd, 8'h55);
    temp = 12'h19A;
    host.write_reg(8'h05, 8'h40);
    pulse(above);
    chk({7'h0, pin_oe}, 8'h01);
    host.read_reg(8'h06, rd);
    chk(rd, 8'h80);
    pulse(below);
    chk({7'h0, pin_oe}, 8'h00);
    host.write_reg(8'h06, 8'hFE);
    host.read_reg(8'h06, rd);
    chk(rd, 8'hAE);
    chk(whole, 8'h19);
    chk({7'h0, pin_oe}, 8'h01);
    chk({6'h0, sda_o, pin_o}, 8'h00);
    pulse(above);
    chk({7'h0, pin_oe}, 8'h00);
    host.read_reg(8'h06, rd);
    chk({7'h0, pin_oe}, 8'h01);
    pulse(above);
    chk({7'h0, pin_oe}, 8'h01);
    pulse(below);
    pulse(above);
    chk({7'h0, pin_oe}, 8'h00);
    period(8'hC8);
    host.write_reg(8'h06, 8'h00);
    period(8'h32);
    host.write_reg(8'h05, 8'h43);
    first_fan_input = 1'h1;
    tick(4);
    chk({6'h0, al1, al2}, 8'h02);
    host.write_reg(8'h05, 8'h47);
    chk({6'h0, al1, al2}, 8'h01);
    host.write_reg(8'h05, 8'h44);
    spin = 1'h1;
    tick(12000);
    near(c1, 8'h01, 8'h03);
    near(c2, 8'h03, 8'h05);
    host.write_reg(8'h05, 8'h6C);
    tick(12000);
    near(c1, 8'h00, 8'h01);
    near(c2, 8'h00, 8'h02);
    // Mid-run reset: straps must be caught again at their new levels
    temp = 12'h192;
    arst_n = 1'h0;
    voltage_ident_inputs = 4'h3;
    tick(6);
    arst_n = 1'h1;
    tick(4);
    host.read_reg(8'h05, rd);
    chk(rd, 8'h53);
    host.read_reg(8'h06, rd);
    chk(rd, 8'h01);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
